// ===== design/sla_pkg.sv
// constants, types and helpers of the sliced alu and accumulator
// Operation
// - slice does arithmetic when logic select low, carry-free logic when high
// - four 4-bit slices plus one lookahead generator give a 16-bit word
// - 20/24-bit words use one generator and ripple through extra slices
// - 28/32-bit words use two 16-bit lookahead blocks, carry rippling between
// - a third lookahead level is used only above 32 bits
// - slice offers a doubling operation, A plus A
// - all-ones flag is high whenever every result bit is high
// - in pass, all-ones flag tells that operand A is all ones
// - in exclusive-or, all-ones flag tells operands are complementary
// - in equivalence, all-ones flag tells operands are identical
// - in subtraction, carry-out gives A at least B or A below B
// - in subtraction minus one, carry-out gives A above B or not
// - accumulator modes: 00 hold, 01 left, 10 right, 11 load
// - accumulator shifts and rotates on the rising clock edge
// - low acc_clear_n clears the accumulator at once, without clock
// - complement control at 1 complements the operand, one's complement
// - two 4-bit registers cascade to an 8-bit adding or subtracting acc
package sla_pkg;

  localparam int WORD_BITS = 32;
  localparam int SLICES    = WORD_BITS / 4;
  localparam int NBLK      = (SLICES + 3) / 4;
  localparam int ADDR_BITS = 8;

  localparam logic [7:0] OFS_OPA        = 8'h00;
  localparam logic [7:0] OFS_OPB        = 8'h04;
  localparam logic [7:0] OFS_CTRL       = 8'h08;
  localparam logic [7:0] OFS_RESULT     = 8'h0C;
  localparam logic [7:0] OFS_FLAGS      = 8'h10;
  localparam logic [7:0] OFS_ACC_CTRL   = 8'h14;
  localparam logic [7:0] OFS_ACC_STEP   = 8'h18;
  localparam logic [7:0] OFS_ACC        = 8'h1C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h24;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h28;

  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_LOGIC_BIT = 4;
  localparam int CTRL_CARRY_BIT = 5;
  localparam int ACC_MODE_LSB   = 0;
  localparam int ACC_COMP_BIT   = 2;
  localparam int ACC_CIN_BIT    = 3;
  localparam int ACC_ROT_BIT    = 4;
  localparam int ACC_SIN_BIT    = 5;
  localparam int FLG_ONES_BIT   = 0;
  localparam int FLG_CARRY_BIT  = 1;
  localparam int INT_ONES       = 0;
  localparam int INT_CARRY      = 1;
  localparam int INT_ACC_CARRY  = 2;
  localparam int INT_BITS       = 3;

  localparam logic [5:0]          CTRL_RST     = 6'h00;
  localparam logic [5:0]          ACC_CTRL_RST = 6'h00;
  localparam logic [INT_BITS-1:0] INT_EN_RST   = 3'h0;
  localparam logic [3:0]          ACC4_RST     = 4'h0;

  localparam logic [3:0] SEL_PASS   = 4'h0;
  localparam logic [3:0] SEL_SUB    = 4'h6;
  localparam logic [3:0] SEL_ADD    = 4'h9;
  localparam logic [3:0] SEL_DOUBLE = 4'hC;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ACC_HOLD  = 2'h0,
    ACC_LEFT  = 2'h1,
    ACC_RIGHT = 2'h2,
    ACC_LOAD  = 2'h3
  } sla_acc_mode_t;

  typedef struct packed
  {
    logic [3:0] f;
    logic       g;
    logic       p;
    logic       ones;
  } sla_slice_out_t;

  typedef struct packed
  {
    logic [3:0] q;
  } sla_acc4_state_t;

  typedef struct packed
  {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 aw_hold;
    logic [ADDR_BITS-1:0] awaddr;
    logic                 w_hold;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [31:0]          opa;
    logic [31:0]          opb;
    logic [5:0]           ctrl;
    logic [5:0]           acc_ctrl;
    logic                 acc_step;
    logic [31:0]          result;
    logic                 ones;
    logic                 carry;
    logic [INT_BITS-1:0]  int_status;
    logic [INT_BITS-1:0]  int_enable;
    logic                 irq;
  } sla_top_state_t;

  function automatic logic [31:0] sla_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[8*i +: 8] = wd[8*i +: 8];
    end
    return m;
  endfunction

endpackage

// ===== design/sla_slice.sv
// one 4-bit alu slice with group generate and propagate
`timescale 1ns/1ps
`default_nettype none
module sla_slice
(
  input  wire logic [3:0]              a,
  input  wire logic [3:0]              b,
  input  wire logic [3:0]              sel,
  input  wire logic                    logic_mode,
  input  wire logic                    cin,
  output var  sla_pkg::sla_slice_out_t res
);
  import sla_pkg::*;

  logic [3:0] op1;
  logic [3:0] op2;
  logic [3:0] c;
  logic       grp;

  // sel 1001 adds, 0000 passes A, so tying sel0 to sel3 gives add-or-pass
  always_comb
  begin
    op1 = a | (b & {4{sel[0]}}) | (~b & {4{sel[1]}});
    op2 = a & ((~b & {4{sel[2]}}) | (b & {4{sel[3]}}));
    // sel 1100 makes both terms A, so the sum is A doubled
    c[0] = cin & ~logic_mode;
    for (int i = 1; i < 4; i++)
      c[i] = ~logic_mode & (op2[i-1] | (op1[i-1] & c[i-1]));
    grp = 1'h0;
    for (int i = 0; i < 4; i++)
      grp = op2[i] | (op1[i] & grp);
    if (logic_mode)
      res.f = ~(op1 ^ op2);
    else
      res.f = op1 ^ op2 ^ c;
    // carries inhibited: no generate or propagate leaves in logic mode
    res.g = grp & ~logic_mode;
    res.p = (&op1) & ~logic_mode;
    res.ones = &res.f;
  end

endmodule
`default_nettype wire

// ===== design/sla_acc4.sv
// 4-bit accumulator register with hold, shift, rotate and load
`timescale 1ns/1ps
`default_nettype none
module sla_acc4
(
  input  wire logic                   clk,
  input  wire logic                   clear_n,
  input  wire sla_pkg::sla_acc_mode_t mode,
  input  wire logic [3:0]             d,
  input  wire logic                   left_in,
  input  wire logic                   right_in,
  output var  logic [3:0]             q
);
  import sla_pkg::*;

  sla_acc4_state_t r;
  sla_acc4_state_t next_r;

  always_comb
  begin
    next_r = r;
    case (mode)
      ACC_HOLD:  next_r = r;
      ACC_LEFT:  next_r.q = {r.q[2:0], left_in};
      ACC_RIGHT: next_r.q = {right_in, r.q[3:1]};
      ACC_LOAD:  next_r.q = d;
      default:   next_r = r;
    endcase
  end

  // clear acts without the clock all moves on the rising edge
  always_ff @(posedge clk or negedge clear_n)
  begin
    if (!clear_n)
      r <= ACC4_RST;
    else
      r <= next_r;
  end

  assign q = r.q;

  AST_ACC_HOLD: assert property (@(posedge clk) disable iff (!clear_n)
    mode == ACC_HOLD |=> $stable(q))
    else $error("accumulator moved in hold");
  AST_ACC_SHIFT: assert property (@(posedge clk) disable iff (!clear_n)
    mode == ACC_RIGHT |=> q == {$past(right_in), $past(q[3:1])})
    else $error("accumulator right shift wrong");
  AST_ACC_CLEAR: assert property (@(posedge clk)
    !clear_n |-> q == ACC4_RST)
    else $error("accumulator not cleared");

endmodule
`default_nettype wire

// ===== design/sla_top.sv
// 32-bit sliced alu with lookahead and 8-bit accumulator on axi4-lite
`timescale 1ns/1ps
`default_nettype none
module sla_top
(
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic                          ACC_CLEAR_N,
  input  wire logic                          AWVALID,
  output var  logic                          AWREADY,
  input  wire logic [sla_pkg::ADDR_BITS-1:0] AWADDR,
  input  wire logic                          WVALID,
  output var  logic                          WREADY,
  input  wire logic [31:0]                   WDATA,
  input  wire logic [3:0]                    WSTRB,
  output var  logic                          BVALID,
  input  wire logic                          BREADY,
  output var  logic [1:0]                    BRESP,
  input  wire logic                          ARVALID,
  output var  logic                          ARREADY,
  input  wire logic [sla_pkg::ADDR_BITS-1:0] ARADDR,
  output var  logic                          RVALID,
  input  wire logic                          RREADY,
  output var  logic [31:0]                   RDATA,
  output var  logic [1:0]                    RRESP,
  output var  logic                          IRQ
);
  import sla_pkg::*;

  sla_top_state_t      r;
  sla_top_state_t      next_r;
  sla_slice_out_t      slice_res [SLICES];
  logic [SLICES-1:0]   sg;
  logic [SLICES-1:0]   sp;
  logic [SLICES-1:0]   scin;
  logic [SLICES-1:0]   sones;
  logic [WORD_BITS-1:0] alu_f;
  logic                alu_ones;
  logic [NBLK:0]       blk_c;
  logic [3:0]          blk_o [NBLK];
  logic [7:0]          acc_q;
  logic [7:0]          acc_opd;
  logic [8:0]          acc_sum;
  logic                acc_clr_n;
  logic                acc_rot;
  logic                acc_sin;
  sla_acc_mode_t       acc_mode;
  logic [INT_BITS-1:0] ev;
  logic [INT_BITS-1:0] clr;
  logic [7:0]          waddr;
  logic [7:0]          raddr;

  // four-wide carry lookahead over group generate and propagate
  function automatic logic [3:0] look4(input logic [3:0] g,
                                       input logic [3:0] p,
                                       input logic       c);
    logic [3:0] o;
    o[0] = g[0] | (p[0] & c);
    o[1] = g[1] | (p[1] & g[0]) | (&p[1:0] & c);
    o[2] = g[2] | (p[2] & g[1]) | (&p[2:1] & g[0]) | (&p[2:0] & c);
    o[3] = g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0])
         | (&p & c);
    return o;
  endfunction

  for (genvar k = 0; k < SLICES; k++)
  begin : g_slice
    sla_slice u_slice
    (
      .a          (r.opa[4*k +: 4]),
      .b          (r.opb[4*k +: 4]),
      .sel        (r.ctrl[CTRL_SEL_LSB +: 4]),
      .logic_mode (r.ctrl[CTRL_LOGIC_BIT]),
      .cin        (scin[k]),
      .res        (slice_res[k])
    );
    assign alu_f[4*k +: 4] = slice_res[k].f;
    assign sg[k]           = slice_res[k].g;
    assign sp[k]           = slice_res[k].p;
    assign sones[k]        = slice_res[k].ones;
  end

  // ones outputs of all slices are and-tied into one flag
  assign alu_ones = &sones;

  // one generator per 16 bits blocks ripple into each other
  // a short top block is a single generator with rippling slices
  // only two levels: a third pays off above 32 bits only
  assign blk_c[0] = r.ctrl[CTRL_CARRY_BIT];
  for (genvar b = 0; b < NBLK; b++)
  begin : g_blk
    assign blk_o[b]       = look4(sg[4*b +: 4], sp[4*b +: 4], blk_c[b]);
    assign blk_c[b+1]     = blk_o[b][3];
    assign scin[4*b +: 4] = {blk_o[b][2:0], blk_c[b]};
  end

  // 8-bit accumulator: two cascaded 4-bit registers
  assign acc_clr_n = RST_N & ACC_CLEAR_N;
  assign acc_rot   = r.acc_ctrl[ACC_ROT_BIT];
  assign acc_sin   = r.acc_ctrl[ACC_SIN_BIT];
  // complement with carry-in 1 subtracts, without it subtracts one more
  assign acc_opd   = r.opb[7:0] ^ {8{r.acc_ctrl[ACC_COMP_BIT]}};
  assign acc_sum   = {1'h0, acc_q} + {1'h0, acc_opd}
                   + {8'h00, r.acc_ctrl[ACC_CIN_BIT]};
  // register only moves on the cycle after a step write
  assign acc_mode  = r.acc_step
                   ? sla_acc_mode_t'(r.acc_ctrl[ACC_MODE_LSB +: 2])
                   : ACC_HOLD;

  sla_acc4 u_acc_lo
  (
    .clk      (CLK),
    .clear_n  (acc_clr_n),
    .mode     (acc_mode),
    .d        (acc_sum[3:0]),
    .left_in  (acc_rot ? acc_q[7] : acc_sin),
    .right_in (acc_q[4]),
    .q        (acc_q[3:0])
  );

  sla_acc4 u_acc_hi
  (
    .clk      (CLK),
    .clear_n  (acc_clr_n),
    .mode     (acc_mode),
    .d        (acc_sum[7:4]),
    .left_in  (acc_q[3]),
    .right_in (acc_rot ? acc_q[0] : acc_sin),
    .q        (acc_q[7:4])
  );

  assign waddr = {r.awaddr[ADDR_BITS-1:2], 2'h0};
  assign raddr = {ARADDR[ADDR_BITS-1:2], 2'h0};

  always_comb
  begin
    next_r          = r;
    next_r.acc_step = 1'h0;
    // alu result and flags are sampled every cycle
    next_r.result   = alu_f;
    next_r.ones     = alu_ones;
    next_r.carry    = blk_c[NBLK];
    ev                = '0;
    ev[INT_ONES]      = alu_ones & ~r.ones;
    ev[INT_CARRY]     = blk_c[NBLK] & ~r.carry;
    ev[INT_ACC_CARRY] = (acc_mode == ACC_LOAD) & acc_sum[8];
    clr               = '0;

    if (AWVALID && r.awready)
    begin
      next_r.aw_hold = 1'h1;
      next_r.awaddr  = AWADDR;
    end
    if (WVALID && r.wready)
    begin
      next_r.w_hold = 1'h1;
      next_r.wdata  = WDATA;
      next_r.wstrb  = WSTRB;
    end
    if (r.bvalid && BREADY)
      next_r.bvalid = 1'h0;

    // address and data may arrive in either order; act once both held
    if (r.aw_hold && r.w_hold && !r.bvalid)
    begin
      next_r.aw_hold = 1'h0;
      next_r.w_hold  = 1'h0;
      next_r.bvalid  = 1'h1;
      next_r.bresp   = RESP_OKAY;
      case (waddr)
        OFS_OPA:
          next_r.opa = sla_merge(r.opa, r.wdata, r.wstrb);
        OFS_OPB:
          next_r.opb = sla_merge(r.opb, r.wdata, r.wstrb);
        OFS_CTRL:
          if (r.wstrb[0])
            next_r.ctrl = r.wdata[5:0];
        OFS_ACC_CTRL:
          if (r.wstrb[0])
            next_r.acc_ctrl = r.wdata[5:0];
        OFS_ACC_STEP:
          next_r.acc_step = 1'h1;
        OFS_INT_CLEAR:
          if (r.wstrb[0])
            clr = r.wdata[INT_BITS-1:0];
        OFS_INT_ENABLE:
          if (r.wstrb[0])
            next_r.int_enable = r.wdata[INT_BITS-1:0];
        OFS_RESULT, OFS_FLAGS, OFS_ACC, OFS_INT_STATUS:
          next_r.bresp = RESP_OKAY;
        default:
          next_r.bresp = RESP_SLVERR;
      endcase
    end

    // an event in the clearing cycle survives the clear
    next_r.int_status = (r.int_status & ~clr) | ev;
    next_r.irq        = |(next_r.int_status & next_r.int_enable);

    if (r.rvalid && RREADY)
      next_r.rvalid = 1'h0;
    if (ARVALID && r.arready)
    begin
      next_r.rvalid = 1'h1;
      next_r.rresp  = RESP_OKAY;
      next_r.rdata  = 32'h0000_0000;
      case (raddr)
        OFS_OPA:        next_r.rdata = r.opa;
        OFS_OPB:        next_r.rdata = r.opb;
        OFS_CTRL:       next_r.rdata[5:0] = r.ctrl;
        OFS_RESULT:     next_r.rdata = r.result;
        OFS_FLAGS:
        begin
          next_r.rdata[FLG_ONES_BIT]  = r.ones;
          next_r.rdata[FLG_CARRY_BIT] = r.carry;
        end
        OFS_ACC_CTRL:   next_r.rdata[5:0] = r.acc_ctrl;
        OFS_ACC:        next_r.rdata[7:0] = acc_q;
        OFS_INT_STATUS: next_r.rdata[INT_BITS-1:0] = r.int_status;
        OFS_INT_ENABLE: next_r.rdata[INT_BITS-1:0] = r.int_enable;
        OFS_ACC_STEP, OFS_INT_CLEAR:
          next_r.rresp = RESP_OKAY;
        default:
          next_r.rresp = RESP_SLVERR;
      endcase
    end

    // one write and one read in flight; ready drops until answered
    next_r.awready = ~next_r.aw_hold & ~next_r.bvalid;
    next_r.wready  = ~next_r.w_hold & ~next_r.bvalid;
    next_r.arready = ~next_r.rvalid;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      r            <= '0;
      r.ctrl       <= CTRL_RST;
      r.acc_ctrl   <= ACC_CTRL_RST;
      r.int_enable <= INT_EN_RST;
    end
    else
      r <= next_r;
  end

  assign AWREADY = r.awready;
  assign WREADY  = r.wready;
  assign BVALID  = r.bvalid;
  assign BRESP   = r.bresp;
  assign ARREADY = r.arready;
  assign RVALID  = r.rvalid;
  assign RDATA   = r.rdata;
  assign RRESP   = r.rresp;
  assign IRQ     = r.irq;

  // reference values for the checks below
  logic        arith;
  logic [3:0]  sel;
  logic        cin;
  logic [32:0] add_ref;
  logic [16:0] add_lo_ref;
  assign arith   = ~r.ctrl[CTRL_LOGIC_BIT];
  assign sel     = r.ctrl[CTRL_SEL_LSB +: 4];
  assign cin     = r.ctrl[CTRL_CARRY_BIT];
  assign add_ref = {1'h0, r.opa} + {1'h0, r.opb} + {32'h0, cin};
  // lower block carry checked against a plain 16-bit sum, not the wiring
  assign add_lo_ref = {1'h0, r.opa[15:0]} + {1'h0, r.opb[15:0]}
                    + {16'h0000, cin};

  AST_LOGIC_NO_CARRY: assert property (@(posedge CLK) disable iff (!RST_N)
    !arith |=> !r.carry)
    else $error("carry seen in logic mode");
  AST_ADD_LOOKAHEAD: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_ADD |=> {r.carry, r.result} == $past(add_ref))
    else $error("lookahead add result wrong");
  AST_BLOCK_RIPPLE: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_ADD |-> scin[4] == add_lo_ref[16]
    && blk_c[2] == blk_o[1][3])
    else $error("upper block not fed by lower block carry");
  AST_DOUBLE: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_DOUBLE && !cin |=> r.result == {$past(r.opa[30:0]), 1'h0})
    else $error("double of A wrong");
  AST_ONES_FLAG: assert property (@(posedge CLK) disable iff (!RST_N)
    r.ones == &r.result)
    else $error("all-ones flag disagrees with result");
  AST_PASS_ONES: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_PASS && !cin |=> r.ones == (&$past(r.opa)))
    else $error("pass flag wrong");
  AST_IDENTICAL: assert property (@(posedge CLK) disable iff (!RST_N)
    !arith && sel == SEL_ADD |=> r.ones == ($past(r.opa) == $past(r.opb)))
    else $error("identity flag wrong");
  AST_COMPLEMENT: assert property (@(posedge CLK) disable iff (!RST_N)
    !arith && sel == SEL_SUB |=> r.ones == ($past(r.opa) == ~$past(r.opb)))
    else $error("complement flag wrong");
  AST_SUB_GE: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_SUB && cin |=> r.carry == ($past(r.opa) >= $past(r.opb)))
    else $error("subtract magnitude wrong");
  AST_SUB_GT: assert property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_SUB && !cin |=> r.carry == ($past(r.opa) > $past(r.opb)))
    else $error("subtract minus one magnitude wrong");
  AST_ACC_LOAD: assert property (@(posedge CLK) disable iff (!acc_clr_n)
    acc_mode == ACC_LOAD |=> acc_q == $past(acc_sum[7:0]))
    else $error("accumulator did not load sum");
  AST_ACC_SUBTRACT: assert property (@(posedge CLK) disable iff (!acc_clr_n)
    acc_mode == ACC_LOAD && r.acc_ctrl[ACC_COMP_BIT] && r.acc_ctrl[ACC_CIN_BIT]
    |=> acc_q == 8'($past(acc_q) - $past(r.opb[7:0])))
    else $error("accumulator subtract wrong");
  AST_ACC_ROTATE: assert property (@(posedge CLK) disable iff (!acc_clr_n)
    acc_mode == ACC_LEFT && acc_rot |=> acc_q == {$past(acc_q[6:0]), $past(acc_q[7])})
    else $error("accumulator rotate left wrong");

  COV_ADD_CARRY: cover property (@(posedge CLK) disable iff (!RST_N)
    arith && sel == SEL_ADD ##1 r.carry);
  COV_ONES: cover property (@(posedge CLK) disable iff (!RST_N)
    !arith && sel == SEL_ADD ##1 r.ones);
  COV_ACC_LOAD: cover property (@(posedge CLK) disable iff (!RST_N)
    acc_mode == ACC_LOAD && acc_sum[8]);
  COV_IRQ: cover property (@(posedge CLK) disable iff (!RST_N)
    !r.irq ##1 r.irq);

endmodule
`default_nettype wire

// ===== tb/sla_ctl.sv
// axi4-lite master standing in for the datapath controller
`timescale 1ns/1ps
`default_nettype none
module sla_ctl
(
  input  wire logic        clk,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [7:0]  awaddr,
  output var  logic        wvalid,
  input  wire logic        wready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  input  wire logic        bvalid,
  output var  logic        bready,
  input  wire logic [1:0]  bresp,
  output var  logic        arvalid,
  input  wire logic        arready,
  output var  logic [7:0]  araddr,
  input  wire logic        rvalid,
  output var  logic        rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
  end

  // address and data go out together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(ta & tw))
    begin
      @(posedge clk);
      if (awready & !ta)
      begin
        ta = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready & !tw)
      begin
        tw = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid)
      @(posedge clk);
    r = bresp;
    bready <= 1'h0;
    // spare edge so registered results settle before the next read
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'h0;
    while (!rvalid)
      @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb/sla_top_bench.sv
// self-checking bench of the sliced alu and 8-bit accumulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module sla_top_bench;
  import sla_pkg::*;
  logic        clk, rst_n, clr_n, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, m_acc, m_opb;
  logic [31:0] wdata, rdata, v, a, b;
  logic [3:0]  wstrb, s;
  logic [1:0]  bresp, rresp, rs;
  int          err_total, checked, cyc, seed;
  logic [3:0]  sel_q [3] = '{SEL_ADD, SEL_SUB, SEL_DOUBLE};
  logic [5:0]  acc_q [10] = '{6'h03, 6'h03, 6'h0F, 6'h01, 6'h21, 6'h11,
                              6'h02, 6'h22, 6'h12, 6'h00};

  sla_top sla_top_i (.CLK(clk), .RST_N(rst_n), .ACC_CLEAR_N(clr_n),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
    .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid),
    .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
    .RRESP(rresp), .IRQ(irq));
  sla_ctl sla_ctl_i (.clk(clk), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hung handshake ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic w(input logic [7:0] ad, input logic [31:0] d);
    sla_ctl_i.wr(ad, d, rs);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, m);
    sla_ctl_i.rd(ad, v, rs);
    `CHK(v & m, e & m)
  endtask

  function automatic logic [32:0] model(logic [3:0] sl, logic [31:0] x, y,
                                        logic c);
    if (sl == SEL_ADD)
      return {1'h0, x} + y + c;
    if (sl == SEL_SUB)
      return {1'h0, x} + {1'h0, ~y} + c;
    return {1'h0, x} + x + c;
  endfunction

  // k masks the carry flag where the operation leaves it undefined
  task automatic alu(input logic [31:0] x, y, input logic [5:0] c,
                     input logic [32:0] e, input logic k);
    w(OFS_OPA, x);
    w(OFS_OPB, y);
    w(OFS_CTRL, {26'h0, c});
    rd_chk(OFS_RESULT, e[31:0], ~32'h0);
    rd_chk(OFS_FLAGS, {30'h0, e[32], &e[31:0]}, {30'h0, k, 1'h1});
  endtask

  task automatic step(input logic [5:0] c);
    logic [7:0] q;
    q = m_acc;
    case (c[1:0])
      2'h1: m_acc = {q[6:0], c[4] ? q[7] : c[5]};
      2'h2: m_acc = {c[4] ? q[0] : c[5], q[7:1]};
      2'h3: m_acc = q + (m_opb ^ {8{c[2]}}) + c[3];
      default: m_acc = q;
    endcase
    w(OFS_ACC_CTRL, {26'h0, c});
    w(OFS_ACC_STEP, 32'h1);
    rd_chk(OFS_ACC, {24'h0, m_acc}, ~32'h0);
  endtask

  initial
  begin
    seed = 32'h687C;
    rst_n = 1'h0;
    clr_n = 1'h1;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    rd_chk(OFS_ACC, 32'h0, ~32'h0);
    for (int i = 0; i < 12; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      s = sel_q[i % 3];
      alu(a, b, {a[5], 1'h0, s}, model(s, a, b, a[5]), 1'h1);
    end
    alu(32'h0000FFFF, 32'h1, {2'h0, SEL_ADD}, 33'h10000, 1'h1);
    alu(32'h00FFFFFF, 32'h1, {2'h0, SEL_ADD}, 33'h1000000, 1'h1);
    alu(~32'h0, 32'h1, {2'h0, SEL_ADD}, 33'h100000000, 1'h1);
    alu(a, a, {2'h2, SEL_SUB}, 33'h100000000, 1'h1);
    alu(a, a, {2'h0, SEL_SUB}, 33'h0FFFFFFFF, 1'h1);
    alu(a, ~a, {2'h1, SEL_SUB}, {1'h0, ~32'h0}, 1'h0);
    alu(a, a, {2'h3, SEL_ADD}, {1'h0, ~32'h0}, 1'h0);
    alu(a, b, {2'h3, SEL_SUB}, {1'h0, a ^ b}, 1'h0);
    alu(~32'h0, b, {2'h0, 4'h0}, {1'h0, ~32'h0}, 1'h0);
    alu(a, b, {2'h0, 4'h9}, model(SEL_ADD, a, b, 1'h0), 1'h1);
    $display("test alu done");
    m_acc = 8'h00;
    foreach (acc_q[i])
    begin
      m_opb = $random(seed);
      w(OFS_OPB, {24'h0, m_opb});
      step(acc_q[i]);
    end
    @(posedge clk);
    clr_n <= 1'h0;
    @(posedge clk);
    clr_n <= 1'h1;
    rd_chk(OFS_ACC, 32'h0, ~32'h0);
    $display("test accumulator done");
    w(OFS_OPA, 32'h0);
    w(OFS_CTRL, {28'h0, SEL_PASS});
    w(OFS_INT_CLEAR, 32'h7);
    w(OFS_INT_ENABLE, 32'h1);
    `CHK(irq, 1'h0)
    w(OFS_OPA, ~32'h0);
    rd_chk(OFS_INT_STATUS, 32'h1, 32'h1);
    `CHK(irq, 1'h1)
    w(OFS_INT_ENABLE, 32'h0);
    `CHK(irq, 1'h0)
    w(OFS_OPA, 32'h0);
    w(OFS_INT_CLEAR, 32'h1);
    w(OFS_INT_ENABLE, 32'h1);
    `CHK(irq, 1'h0)
    $display("test interrupt done");
    sla_ctl_i.wr(8'h40, 32'h1, rs);
    `CHK(rs, RESP_SLVERR)
    sla_ctl_i.rd(8'h40, v, rs);
    `CHK({rs, v}, {RESP_SLVERR, 32'h0})
    $display("test unmapped done");
    stop_test();
  end
endmodule
`default_nettype wire
